// ===== include/lefs_pkg.sv
`default_nettype none
package lefs_pkg;
	// Register byte offsets on the AXI4-Lite bus
	localparam int unsigned ADDR_W    = 8;
	localparam logic [7:0]  OFS_FLAGS = 8'h00;
	localparam logic [7:0]  OFS_MASK  = 8'h04;
	localparam logic [7:0]  OFS_CTRL  = 8'h08;
	localparam logic [7:0]  OFS_VECT  = 8'h0C;

	// Flag field positions in link_flags_status and the mask
	localparam int unsigned BIT_BUS  = 30;
	localparam int unsigned BIT_CE   = 29;
	localparam int unsigned BIT_SYNC = 28;

	// Field positions in global_ctrl_1
	localparam int unsigned BIT_MOD_RUN = 0;  // Module reset bit, 0 clears flags without a set event
	localparam int unsigned BIT_SW_HOLD = 1;  // sw_hold_reset_bit, 0 clears flags without a set event
	localparam int unsigned BIT_CKSEL   = 2;  // checksum_kind_sel, 1 = enhanced
	localparam int unsigned BIT_LIN     = 6;  // LIN mode enable

	// Reset values
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [2:0]  MASK_RST = 3'h0;

	// Flag indices, lowest index has the highest vector priority
	localparam int unsigned NFLAG   = 3;
	localparam int unsigned FI_BUS  = 0;
	localparam int unsigned FI_SYNC = 1;
	localparam int unsigned FI_CE   = 2;

	// irq_vector_offset codes, values arbitrary
	localparam logic [4:0] VEC_NONE = 5'h00;
	localparam logic [4:0] VEC_BUS  = 5'h0A;
	localparam logic [4:0] VEC_SYNC = 5'h0B;
	localparam logic [4:0] VEC_CE   = 5'h0C;

	// AXI response codes
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Master to slave signals of the register bus
	typedef struct packed {
		logic              awvalid;
		logic [ADDR_W-1:0] awaddr;
		logic              wvalid;
		logic [31:0]       wdata;
		logic [3:0]        wstrb;
		logic              bready;
		logic              arvalid;
		logic [ADDR_W-1:0] araddr;
		logic              rready;
	} lefs_axi_req_t;

	// Slave to master signals of the register bus
	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} lefs_axi_rsp_t;
endpackage
`default_nettype wire

// ===== logic/lefs_cksum.sv
`timescale 1ns/1ns
`default_nettype none
module lefs_cksum (
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       kind_enh,
	input  wire logic       start,
	input  wire logic [7:0] pid,
	input  wire logic       valid,
	input  wire logic [7:0] byte_in,
	input  wire logic       last,
	output logic            mismatch
);
	logic [7:0] sum_r;        // Running carry-wrapped sum
	logic [7:0] sum_nxt;
	logic       mismatch_r;   // One-cycle mismatch pulse
	logic       mismatch_nxt;
	logic [8:0] sum9;         // Sum with carry out
	logic [7:0] wrapped;      // Carry folded back in

	// Enhanced sums include the identifier, classic starts from zero
	always_comb begin
		sum9         = {1'b0, sum_r} + {1'b0, byte_in};
		wrapped      = sum9[7:0] + {7'h00, sum9[8]};
		sum_nxt      = sum_r;
		mismatch_nxt = 1'b0;
		if (start) begin
			sum_nxt = kind_enh ? pid : 8'h00;
		end else if (valid && last) begin
			mismatch_nxt = (~sum_r != byte_in);
		end else if (valid) begin
			sum_nxt = wrapped;
		end
	end

	// Sum and result registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sum_r      <= 8'h00;
			mismatch_r <= 1'b0;
		end else begin
			sum_r      <= sum_nxt;
			mismatch_r <= mismatch_nxt;
		end
	end

	assign mismatch = mismatch_r;

	property p_ck_init;
		@(posedge aclk) disable iff (!aresetn)
		start |=> sum_r == ($past(kind_enh) ? $past(pid) : 8'h00);
	endproperty
	a_ck_init: assert property (p_ck_init) else $error("checksum seed ignores kind select");
endmodule
`default_nettype wire

// ===== logic/lefs_flag_cell.sv
`timescale 1ns/1ns
`default_nettype none
module lefs_flag_cell (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic set_evt,
	input  wire logic clr_evt,
	output logic      flag
);
	logic flag_r;   // Sticky error flag
	logic flag_nxt; // Its next value

	// Set beats clear so a fault in the clearing cycle survives
	always_comb begin
		if (set_evt) begin
			flag_nxt = 1'b1;
		end else if (clr_evt) begin
			flag_nxt = 1'b0;
		end else begin
			flag_nxt = flag_r;
		end
	end

	// System reset clears the flag
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flag_r <= 1'b0;
		end else begin
			flag_r <= flag_nxt;
		end
	end

	assign flag = flag_r;

	property p_set_wins;
		@(posedge aclk) disable iff (!aresetn)
		(set_evt && clr_evt) |=> flag_r;
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("flag lost set against clear");
endmodule
`default_nettype wire

// ===== logic/lefs_top.sv
`timescale 1ns/1ns
`default_nettype none
module lefs_top (
	input  wire logic                   aclk,
	input  wire logic                   aresetn,
	input  wire lefs_pkg::lefs_axi_req_t axi_req,
	output lefs_pkg::lefs_axi_rsp_t     axi_rsp,
	input  wire logic                   phys_bus_fault,
	input  wire logic                   sync_field_incons,
	input  wire logic                   hdr_rx_active,
	input  wire logic                   rx_node,
	input  wire logic                   ck_start,
	input  wire logic [7:0]             ck_pid,
	input  wire logic                   ck_valid,
	input  wire logic [7:0]             ck_byte,
	input  wire logic                   ck_last,
	output logic                        irq
);
	localparam int unsigned NF = lefs_pkg::NFLAG;

	// Bus channel state
	logic                           aw_got_r;   // Write address held
	logic                           aw_got_nxt;
	logic                           w_got_r;    // Write data held
	logic                           w_got_nxt;
	logic [lefs_pkg::ADDR_W-1:0]    awaddr_r;   // Held write address
	logic [lefs_pkg::ADDR_W-1:0]    awaddr_nxt;
	logic [31:0]                    wdata_r;    // Held write data
	logic [31:0]                    wdata_nxt;
	logic [3:0]                     wstrb_r;    // Held byte strobes
	logic [3:0]                     wstrb_nxt;
	lefs_pkg::lefs_axi_rsp_t        rsp_r;      // All bus outputs
	lefs_pkg::lefs_axi_rsp_t        rsp_nxt;

	// Software state
	logic [31:0]                    ctrl_r;     // global_ctrl_1
	logic [31:0]                    ctrl_nxt;
	logic [NF-1:0]                  mask_r;     // Interrupt mask
	logic [NF-1:0]                  mask_nxt;
	logic                           irq_r;      // Interrupt line
	logic                           irq_nxt;

	// Per-cycle decode
	logic                           aw_hs;      // Address accepted now
	logic                           w_hs;       // Data accepted now
	logic                           ar_hs;      // Read accepted now
	logic                           wr_do;      // Write executes now
	logic [lefs_pkg::ADDR_W-1:0]    wa;         // Effective write address
	logic [31:0]                    wd;         // Effective write data
	logic [3:0]                     ws;         // Effective strobes
	logic                           vect_rd;    // Vector read in progress
	logic                           lin_mode;   // LIN mode selected
	logic                           hold_clr;   // Module held in reset
	logic [NF-1:0]                  flags;      // Current flag levels
	logic [NF-1:0]                  set_v;      // Hardware set events
	logic [NF-1:0]                  w1c_v;      // Software write-one clears
	logic [NF-1:0]                  vec_clr_v;  // Vector read clears
	logic [NF-1:0]                  clr_v;      // All clear events
	logic [NF-1:0]                  pick;       // Vector winner, one-hot
	logic                           ck_err;     // Checksum mismatch pulse
	logic [31:0]                    rd_val;     // Read mux result
	logic                           rd_ok;      // Read address mapped

	// Bit position of a flag inside the status word
	function automatic int unsigned flag_pos(input int unsigned i);
		unique case (i)
			lefs_pkg::FI_BUS:  flag_pos = lefs_pkg::BIT_BUS;
			lefs_pkg::FI_SYNC: flag_pos = lefs_pkg::BIT_SYNC;
			default:           flag_pos = lefs_pkg::BIT_CE;
		endcase
	endfunction

	// Byte lane of a bit is enabled by its strobe
	function automatic logic lane_on(input logic [3:0] strb, input int unsigned pos);
		lane_on = strb[pos / 8];
	endfunction

	// Register match, low address bits ignored for word alignment
	function automatic logic hit(input logic [lefs_pkg::ADDR_W-1:0] a, input logic [7:0] ofs);
		hit = (a[lefs_pkg::ADDR_W-1:2] == ofs[lefs_pkg::ADDR_W-1:2]);
	endfunction

	// Address and data may come in either order; both are needed
	assign aw_hs    = axi_req.awvalid & rsp_r.awready;
	assign w_hs     = axi_req.wvalid & rsp_r.wready;
	assign ar_hs    = axi_req.arvalid & rsp_r.arready;
	assign wr_do    = (aw_got_r | aw_hs) & (w_got_r | w_hs);
	assign wa       = aw_got_r ? awaddr_r : axi_req.awaddr;
	assign wd       = w_got_r ? wdata_r : axi_req.wdata;
	assign ws       = w_got_r ? wstrb_r : axi_req.wstrb;
	assign vect_rd  = ar_hs & hit(axi_req.araddr, lefs_pkg::OFS_VECT);
	assign lin_mode = ctrl_r[lefs_pkg::BIT_LIN];
	// Either reset bit at zero clears every flag that has no set event this cycle
	assign hold_clr = ~ctrl_r[lefs_pkg::BIT_MOD_RUN] | ~ctrl_r[lefs_pkg::BIT_SW_HOLD];

	// Checksum checker, kind chosen by software
	lefs_cksum u_cksum (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.kind_enh (ctrl_r[lefs_pkg::BIT_CKSEL]),
		.start    (ck_start),
		.pid      (ck_pid),
		.valid    (ck_valid & rx_node),
		.byte_in  (ck_byte),
		.last     (ck_last),
		.mismatch (ck_err)
	);

	// Detector events, accepted only in LIN mode
	always_comb begin
		set_v                    = '0;
		set_v[lefs_pkg::FI_BUS]  = lin_mode & phys_bus_fault;
		set_v[lefs_pkg::FI_SYNC] = lin_mode & sync_field_incons & hdr_rx_active;
		set_v[lefs_pkg::FI_CE]   = lin_mode & ck_err & rx_node;
	end

	// Vector picks the highest-priority pending enabled flag
	always_comb begin
		pick = '0;
		for (int i = NF - 1; i >= 0; i--) begin
			if (flags[i] && mask_r[i]) begin
				pick    = '0;
				pick[i] = 1'b1;
			end
		end
	end

	// Clear sources per flag
	generate
		for (genvar g = 0; g < NF; g++) begin : g_flag
			// Write of one clears, zero has no effect, LIN mode only
			assign w1c_v[g] = wr_do & hit(wa, lefs_pkg::OFS_FLAGS) & lin_mode
				& lane_on(ws, flag_pos(g)) & wd[flag_pos(g)];
			assign vec_clr_v[g] = vect_rd & pick[g];
			// Three clear events merged; system reset is in the cell
			assign clr_v[g] = w1c_v[g] | vec_clr_v[g] | hold_clr;

			lefs_flag_cell u_cell (
				.aclk    (aclk),
				.aresetn (aresetn),
				.set_evt (set_v[g]),
				.clr_evt (clr_v[g]),
				.flag    (flags[g])
			);
		end
	endgenerate

	// Read data mux; unused flag, mask and vector bits read zero, control reads back all 32 stored bits
	always_comb begin
		rd_val = 32'h0000_0000;
		rd_ok  = 1'b1;
		if (hit(axi_req.araddr, lefs_pkg::OFS_FLAGS)) begin
			for (int i = 0; i < NF; i++) begin
				rd_val[flag_pos(i)] = flags[i];
			end
		end else if (hit(axi_req.araddr, lefs_pkg::OFS_MASK)) begin
			for (int i = 0; i < NF; i++) begin
				rd_val[flag_pos(i)] = mask_r[i];
			end
		end else if (hit(axi_req.araddr, lefs_pkg::OFS_CTRL)) begin
			rd_val = ctrl_r;
		end else if (hit(axi_req.araddr, lefs_pkg::OFS_VECT)) begin
			// Encoded source; the read also clears it
			unique case (1'b1)
				pick[lefs_pkg::FI_BUS]:  rd_val[4:0] = lefs_pkg::VEC_BUS;
				pick[lefs_pkg::FI_SYNC]: rd_val[4:0] = lefs_pkg::VEC_SYNC;
				pick[lefs_pkg::FI_CE]:   rd_val[4:0] = lefs_pkg::VEC_CE;
				default:                 rd_val[4:0] = lefs_pkg::VEC_NONE;
			endcase
		end else begin
			rd_ok = 1'b0;
		end
	end

	// Bus handshake and software register next values
	always_comb begin
		aw_got_nxt = (aw_got_r | aw_hs) & ~wr_do;
		w_got_nxt  = (w_got_r | w_hs) & ~wr_do;
		awaddr_nxt = aw_hs ? axi_req.awaddr : awaddr_r;
		wdata_nxt  = w_hs ? axi_req.wdata : wdata_r;
		wstrb_nxt  = w_hs ? axi_req.wstrb : wstrb_r;
		ctrl_nxt   = ctrl_r;
		mask_nxt   = mask_r;
		rsp_nxt    = rsp_r;
		// Write response and register update
		if (wr_do) begin
			rsp_nxt.bvalid = 1'b1;
			rsp_nxt.bresp  = lefs_pkg::RESP_OKAY;
			if (hit(wa, lefs_pkg::OFS_CTRL)) begin
				for (int b = 0; b < 4; b++) begin
					if (ws[b]) begin
						ctrl_nxt[b*8 +: 8] = wd[b*8 +: 8];
					end
				end
			end else if (hit(wa, lefs_pkg::OFS_MASK)) begin
				for (int i = 0; i < NF; i++) begin
					if (lane_on(ws, flag_pos(i))) begin
						mask_nxt[i] = wd[flag_pos(i)];
					end
				end
			end else if (!hit(wa, lefs_pkg::OFS_FLAGS)) begin
				// Vector is read only; it errs like an unmapped word
				rsp_nxt.bresp = lefs_pkg::RESP_SLVERR;
			end
		end else if (rsp_r.bvalid && axi_req.bready) begin
			rsp_nxt.bvalid = 1'b0;
		end
		// Read response
		if (ar_hs) begin
			rsp_nxt.rvalid = 1'b1;
			rsp_nxt.rdata  = rd_val;
			rsp_nxt.rresp  = rd_ok ? lefs_pkg::RESP_OKAY : lefs_pkg::RESP_SLVERR;
		end else if (rsp_r.rvalid && axi_req.rready) begin
			rsp_nxt.rvalid = 1'b0;
		end
		// One of each transfer at a time keeps the slave simple
		rsp_nxt.awready = ~aw_got_nxt & ~rsp_nxt.bvalid;
		rsp_nxt.wready  = ~w_got_nxt & ~rsp_nxt.bvalid;
		rsp_nxt.arready = ~rsp_nxt.rvalid;
		irq_nxt         = |(flags & mask_r);
	end

	// Registers; readies come up one cycle after reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_r <= 1'b0;
			w_got_r  <= 1'b0;
			awaddr_r <= '0;
			wdata_r  <= 32'h0000_0000;
			wstrb_r  <= 4'h0;
			rsp_r    <= '0;
			ctrl_r   <= lefs_pkg::CTRL_RST;
			mask_r   <= lefs_pkg::MASK_RST;
			irq_r    <= 1'b0;
		end else begin
			aw_got_r <= aw_got_nxt;
			w_got_r  <= w_got_nxt;
			awaddr_r <= awaddr_nxt;
			wdata_r  <= wdata_nxt;
			wstrb_r  <= wstrb_nxt;
			rsp_r    <= rsp_nxt;
			ctrl_r   <= ctrl_nxt;
			mask_r   <= mask_nxt;
			irq_r    <= irq_nxt;
		end
	end

	assign axi_rsp = rsp_r;
	assign irq     = irq_r;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// Both halves of a write, then the response
	sequence s_wr_taken;
		wr_do && !rsp_r.bvalid;
	endsequence
	sequence s_wr_answer;
		rsp_r.bvalid && !rsp_r.awready && !rsp_r.wready;
	endsequence

	property p_bus_set;
		lin_mode && phys_bus_fault |=> flags[lefs_pkg::FI_BUS];
	endproperty
	a_bus_set: assert property (p_bus_set) else $error("bus fault did not set flag");

	property p_bus_clr;
		clr_v[lefs_pkg::FI_BUS] && !set_v[lefs_pkg::FI_BUS] |=> !flags[lefs_pkg::FI_BUS];
	endproperty
	a_bus_clr: assert property (p_bus_clr) else $error("bus fault flag not cleared");

	property p_w0_keeps;
		flags[lefs_pkg::FI_BUS] && wr_do && hit(wa, lefs_pkg::OFS_FLAGS) && !wd[lefs_pkg::BIT_BUS]
			&& !hold_clr && !vec_clr_v[lefs_pkg::FI_BUS] |=> flags[lefs_pkg::FI_BUS];
	endproperty
	a_w0_keeps: assert property (p_w0_keeps) else $error("write of zero changed flag");

	property p_read_val;
		ar_hs && hit(axi_req.araddr, lefs_pkg::OFS_FLAGS)
			|=> rsp_r.rvalid && rsp_r.rdata[lefs_pkg::BIT_CE] == $past(flags[lefs_pkg::FI_CE]);
	endproperty
	a_read_val: assert property (p_read_val) else $error("flag read value wrong");

	property p_ce_set;
		lin_mode && ck_err && rx_node |=> flags[lefs_pkg::FI_CE];
	endproperty
	a_ce_set: assert property (p_ce_set) else $error("checksum error did not set flag");

	property p_ce_vec_clr;
		vect_rd && pick[lefs_pkg::FI_CE] && !set_v[lefs_pkg::FI_CE] |=> !flags[lefs_pkg::FI_CE];
	endproperty
	a_ce_vec_clr: assert property (p_ce_vec_clr) else $error("vector read kept checksum flag");

	property p_sync_set;
		lin_mode && sync_field_incons && hdr_rx_active |=> flags[lefs_pkg::FI_SYNC];
	endproperty
	a_sync_set: assert property (p_sync_set) else $error("sync error did not set flag");

	property p_no_lin_write;
		!lin_mode && flags[lefs_pkg::FI_SYNC] && !hold_clr && !vect_rd && !set_v[lefs_pkg::FI_SYNC]
			|=> flags[lefs_pkg::FI_SYNC];
	endproperty
	a_no_lin_write: assert property (p_no_lin_write) else $error("flag cleared outside LIN mode");

	property p_set_first;
		set_v[lefs_pkg::FI_BUS] && clr_v[lefs_pkg::FI_BUS] |=> flags[lefs_pkg::FI_BUS] ##1 irq_r == $past(irq_nxt);
	endproperty
	a_set_first: assert property (p_set_first) else $error("clear beat a simultaneous set");

	property p_wr_resp;
		s_wr_taken |=> s_wr_answer;
	endproperty
	a_wr_resp: assert property (p_wr_resp) else $error("write response not one cycle after taking");
endmodule
`default_nettype wire

// ===== tb/lefs_lin_node.sv
`timescale 1ns/1ns
`default_nettype none
// Far-side LIN node seen through the transceiver and detectors
module lefs_lin_node (
	input  wire logic  aclk,
	output logic       phys_bus_fault,
	output logic       sync_field_incons,
	output logic       hdr_rx_active,
	output logic       rx_node,
	output logic       ck_start,
	output logic [7:0] ck_pid,
	output logic       ck_valid,
	output logic [7:0] ck_byte,
	output logic       ck_last
);
	// Quiet bus at time zero
	initial begin
		{phys_bus_fault, sync_field_incons, hdr_rx_active, rx_node, ck_start, ck_valid, ck_last} = '0;
		ck_pid = 8'hA5;
		ck_byte = 8'h5A;
	end

	// One-cycle fault; sel 0 bus fault, else sync field with header flag hdr
	task automatic pulse(input int sel, input logic hdr);
		@(posedge aclk);
		hdr_rx_active <= hdr;
		if (sel == 0) phys_bus_fault <= 1'b1;
		else sync_field_incons <= 1'b1;
		@(posedge aclk);
		{phys_bus_fault, sync_field_incons, hdr_rx_active} <= '0;
	endtask

	// Bus fault held as a level, for set-versus-clear races
	task automatic hold_fault(input logic v);
		@(posedge aclk);
		phys_bus_fault <= v;
	endtask

	// Three data bytes and checksum; enh folds pid in, bad corrupts the checksum
	task automatic frame(input logic [7:0] pid, input logic enh, input logic bad);
		logic [8:0] s;
		logic [7:0] d [3];
		d = '{8'hF0, 8'h37, 8'hC9};
		s = enh ? {1'b0, pid} : 9'h000;
		@(posedge aclk);
		rx_node <= 1'b1;
		ck_start <= 1'b1;
		ck_pid <= pid;
		foreach (d[i]) begin
			@(posedge aclk);
			ck_start <= 1'b0;
			ck_valid <= 1'b1;
			ck_byte <= d[i];
			s = {1'b0, s[7:0]} + {1'b0, d[i]};
			s = {1'b0, s[7:0]} + {8'h00, s[8]};
		end
		@(posedge aclk);
		ck_last <= 1'b1;
		ck_byte <= ~s[7:0] ^ {7'h00, bad};
		@(posedge aclk);
		ck_valid <= 1'b0;
		ck_last <= 1'b0;
		// Released lines show the inverse, not a stale value
		ck_byte <= ~ck_byte;
		ck_pid <= ~ck_pid;
		repeat (3) @(posedge aclk);
		rx_node <= 1'b0;
	endtask
endmodule
`default_nettype wire

// ===== tb/lefs_top_tb.sv
`timescale 1ns/1ns
`default_nettype none
// Self-checking bench for the LIN error flag bank
module lefs_top_tb;
	localparam logic [31:0] F_BUS = 32'h4000_0000;  // Bus fault flag
	localparam logic [31:0] F_CE  = 32'h2000_0000;  // Checksum flag
	localparam logic [31:0] F_SF  = 32'h1000_0000;  // Sync field flag
	localparam logic [31:0] RUN   = 32'h0000_0043;  // Run, no hold, LIN mode

	logic                    aclk;             // Module clock
	logic                    aresetn;          // Sync reset
	lefs_pkg::lefs_axi_req_t req;              // Bus requests
	lefs_pkg::lefs_axi_rsp_t rsp;              // Bus answers
	logic                    fault, sync_err, hdr, rxn, cks, ckv, ckl, irq;
	logic [7:0]              pid, ckb;
	logic [31:0]             rv;               // Last read data
	logic [1:0]              rr;               // Last response
	int                      errors, samples_checked, cyc;

	// 250 MHz clock
	initial aclk = 1'b0;
	always #2 aclk = ~aclk;

	lefs_top i_lefs_top (.aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp), .phys_bus_fault(fault),
		.sync_field_incons(sync_err), .hdr_rx_active(hdr), .rx_node(rxn), .ck_start(cks), .ck_pid(pid),
		.ck_valid(ckv), .ck_byte(ckb), .ck_last(ckl), .irq(irq));
	lefs_lin_node i_lefs_lin_node (.aclk(aclk), .phys_bus_fault(fault), .sync_field_incons(sync_err),
		.hdr_rx_active(hdr), .rx_node(rxn), .ck_start(cks), .ck_pid(pid), .ck_valid(ckv), .ck_byte(ckb),
		.ck_last(ckl));

	// Verdict and end of run
	task automatic complete_run();
		if (errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	// Hang guard, far above the real run length
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 20000) begin
			errors++;
			complete_run();
		end
	end

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			errors++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Write; address and data offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aw, w;
		aw = 1'b0;
		w = 1'b0;
		@(posedge aclk);
		req.awvalid <= 1'b1;
		req.awaddr <= a;
		req.wvalid <= 1'b1;
		req.wdata <= d;
		req.wstrb <= 4'hF;
		req.bready <= 1'b1;
		while (!(aw && w)) begin
			@(posedge aclk);
			if (rsp.awready && !aw) begin
				aw = 1'b1;
				req.awvalid <= 1'b0;
			end
			if (rsp.wready && !w) begin
				w = 1'b1;
				req.wvalid <= 1'b0;
			end
		end
		// No cycle count assumed, only the guard ends this
		while (rsp.bvalid !== 1'b1) @(posedge aclk);
		rr = rsp.bresp;
		req.bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		req.arvalid <= 1'b1;
		req.araddr <= a;
		req.rready <= 1'b1;
		do @(posedge aclk); while (rsp.arready !== 1'b1);
		req.arvalid <= 1'b0;
		do @(posedge aclk); while (rsp.rvalid !== 1'b1);
		rv = rsp.rdata;
		rr = rsp.rresp;
		req.rready <= 1'b0;
	endtask

	task automatic fl(input logic [31:0] e);
		rd(lefs_pkg::OFS_FLAGS);
		chk("link_flags_status", e, rv);
	endtask

	// Reset values, and faults ignored while held in reset by control
	task automatic t_reset();
		fl(32'h0);
		rd(lefs_pkg::OFS_MASK);
		chk("mask", 32'h0, rv);
		rd(lefs_pkg::OFS_CTRL);
		chk("global_ctrl_1", lefs_pkg::CTRL_RST, rv);
		i_lefs_lin_node.pulse(0, 1'b0);
		fl(32'h0);
	endtask

	// Bus fault set, write-0 bits keep it, write-1 clears it
	task automatic t_pbe();
		wr(lefs_pkg::OFS_CTRL, RUN);
		i_lefs_lin_node.pulse(0, 1'b0);
		fl(F_BUS);
		wr(lefs_pkg::OFS_FLAGS, ~F_BUS);
		fl(F_BUS);
		wr(lefs_pkg::OFS_FLAGS, F_BUS);
		fl(32'h0);
	endtask

	// Outside LIN mode: no set, and flag writes are ignored
	task automatic t_notlin();
		wr(lefs_pkg::OFS_CTRL, 32'h0000_0003);
		i_lefs_lin_node.pulse(0, 1'b0);
		fl(32'h0);
		wr(lefs_pkg::OFS_CTRL, RUN);
		i_lefs_lin_node.pulse(0, 1'b0);
		wr(lefs_pkg::OFS_CTRL, 32'h0000_0003);
		wr(lefs_pkg::OFS_FLAGS, F_BUS);
		fl(F_BUS);
		wr(lefs_pkg::OFS_CTRL, RUN);
		wr(lefs_pkg::OFS_FLAGS, F_BUS);
		fl(32'h0);
	endtask

	// Checksum: classic and enhanced kinds, good and bad
	task automatic t_cksum();
		i_lefs_lin_node.frame(8'h8B, 1'b0, 1'b0);
		fl(32'h0);
		i_lefs_lin_node.frame(8'h8B, 1'b0, 1'b1);
		fl(F_CE);
		wr(lefs_pkg::OFS_FLAGS, F_CE);
		fl(32'h0);
		wr(lefs_pkg::OFS_CTRL, RUN | 32'h4);
		i_lefs_lin_node.frame(8'h8B, 1'b0, 1'b0);
		fl(F_CE);
		wr(lefs_pkg::OFS_FLAGS, F_CE);
		i_lefs_lin_node.frame(8'h8B, 1'b1, 1'b0);
		fl(32'h0);
		wr(lefs_pkg::OFS_CTRL, RUN);
	endtask

	// Sync field error only counts during header reception
	task automatic t_sync();
		i_lefs_lin_node.pulse(1, 1'b0);
		fl(32'h0);
		i_lefs_lin_node.pulse(1, 1'b1);
		fl(F_SF);
		wr(lefs_pkg::OFS_MASK, F_SF);
		rd(lefs_pkg::OFS_VECT);
		chk("irq_vector_offset", {27'h0, lefs_pkg::VEC_SYNC}, rv);
		fl(32'h0);
		wr(lefs_pkg::OFS_MASK, 32'h0);
		wr(lefs_pkg::OFS_FLAGS, F_SF);
	endtask

	// Module reset and sw hold bits each clear both flags
	task automatic t_hold();
		logic [31:0] h [2];
		h = '{32'h0000_0042, 32'h0000_0041};
		foreach (h[i]) begin
			i_lefs_lin_node.pulse(0, 1'b0);
			i_lefs_lin_node.frame(8'h21, 1'b0, 1'b1);
			fl(F_BUS | F_CE);
			wr(lefs_pkg::OFS_CTRL, h[i]);
			wr(lefs_pkg::OFS_CTRL, RUN);
			fl(32'h0);
		end
	endtask

	// Interrupt masked, raised, and cleared by vector reads in priority
	task automatic t_irq();
		i_lefs_lin_node.pulse(0, 1'b0);
		repeat (2) @(posedge aclk);
		#1 chk("irq", 32'h0, {31'h0, irq});
		wr(lefs_pkg::OFS_MASK, F_BUS | F_CE);
		repeat (2) @(posedge aclk);
		#1 chk("irq", 32'h1, {31'h0, irq});
		i_lefs_lin_node.frame(8'h21, 1'b0, 1'b1);
		rd(lefs_pkg::OFS_VECT);
		chk("irq_vector_offset", {27'h0, lefs_pkg::VEC_BUS}, rv);
		fl(F_CE);
		rd(lefs_pkg::OFS_VECT);
		chk("irq_vector_offset", {27'h0, lefs_pkg::VEC_CE}, rv);
		fl(32'h0);
		#1 chk("irq", 32'h0, {31'h0, irq});
	endtask

	// Set held during hold-clear and write-1 clear wins
	task automatic t_prio();
		i_lefs_lin_node.hold_fault(1'b1);
		wr(lefs_pkg::OFS_CTRL, 32'h0000_0042);
		wr(lefs_pkg::OFS_FLAGS, F_BUS);
		fl(F_BUS);
		i_lefs_lin_node.hold_fault(1'b0);
		fl(32'h0);
		wr(lefs_pkg::OFS_CTRL, RUN);
	endtask

	// System reset in mid-run clears flags and control
	task automatic t_sysrst();
		i_lefs_lin_node.pulse(0, 1'b0);
		fl(F_BUS);
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		fl(32'h0);
		rd(lefs_pkg::OFS_CTRL);
		chk("global_ctrl_1", 32'h0, rv);
	endtask

	// Unmapped and read-only places refused
	task automatic t_bus();
		wr(8'h10, 32'hFFFF_FFFF);
		chk("bresp", {30'h0, lefs_pkg::RESP_SLVERR}, {30'h0, rr});
		rd(8'h10);
		chk("rresp", {30'h0, lefs_pkg::RESP_SLVERR}, {30'h0, rr});
		chk("rdata", 32'h0, rv);
		wr(lefs_pkg::OFS_VECT, 32'h0);
		chk("bresp", {30'h0, lefs_pkg::RESP_SLVERR}, {30'h0, rr});
	endtask

	// Main sequence
	initial begin
		errors = 0;
		samples_checked = 0;
		req = '0;
		aresetn = 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_pbe();
		t_notlin();
		t_cksum();
		t_sync();
		t_hold();
		t_irq();
		t_prio();
		t_bus();
		t_sysrst();
		complete_run();
	end
endmodule
`default_nettype wire
